//--- rtl/dmac_pkg.sv
// Purpose: shared constants and types of the multiply-accumulate datapath
// Assumes: 10 MHz core clock, AHB-Lite register access
// Notes:
package dmac_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] DMAC_OP_A_OFS = 8'h00;
  localparam logic [7:0] DMAC_OP_B_OFS = 8'h04;
  localparam logic [7:0] DMAC_CMD_OFS = 8'h08;
  localparam logic [7:0] DMAC_CORE_CTL_OFS = 8'h0C;
  localparam logic [7:0] DMAC_TRAP_CTL_OFS = 8'h10;
  localparam logic [7:0] DMAC_STATUS_OFS = 8'h14;
  localparam logic [7:0] DMAC_ACC_FIRST_LO_OFS = 8'h18;
  localparam logic [7:0] DMAC_ACC_FIRST_HI_OFS = 8'h1C;
  localparam logic [7:0] DMAC_ACC_SECOND_LO_OFS = 8'h20;
  localparam logic [7:0] DMAC_ACC_SECOND_HI_OFS = 8'h24;
  localparam logic [7:0] DMAC_PRODUCT_OFS = 8'h28;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DMAC_CTL_FIRST_CLIP_EN_BIT = 7;
  localparam int DMAC_CTL_SECOND_CLIP_EN_BIT = 6;
  localparam int DMAC_CTL_CLIP_MODE_BIT = 4;
  localparam int DMAC_CTL_FRAC_BIT = 0;
  localparam int DMAC_TRAP_FIRST_EN_BIT = 0;
  localparam int DMAC_TRAP_SECOND_EN_BIT = 1;
  localparam int DMAC_ST_FIRST_GUARD_BIT = 0;
  localparam int DMAC_ST_SECOND_GUARD_BIT = 1;
  localparam int DMAC_ST_FIRST_CLIP_BIT = 2;
  localparam int DMAC_ST_SECOND_CLIP_BIT = 3;
  localparam int DMAC_ST_EITHER_GUARD_BIT = 4;
  localparam int DMAC_ST_EITHER_CLIP_BIT = 5;
  localparam int DMAC_ST_FIRST_CATA_BIT = 6;
  localparam int DMAC_ST_SECOND_CATA_BIT = 7;
  localparam int DMAC_ST_TRAP_BIT = 8;
  // command word fields
  localparam int DMAC_CMD_OP_LSB = 0;
  localparam int DMAC_CMD_ACC_BIT = 4;
  localparam int DMAC_CMD_SIGN_A_BIT = 5;
  localparam int DMAC_CMD_SIGN_B_BIT = 6;
  localparam int DMAC_CMD_BYTE_BIT = 7;
  localparam int DMAC_CMD_SHIFT_LSB = 8;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DMAC_CORE_CTL_RST = 8'h00;
  localparam logic [1:0] DMAC_TRAP_CTL_RST = 2'h0;
  localparam logic [39:0] DMAC_ACC_RST = 40'h00_0000_0000;
  // ----------------------------------------------------------------
  // widths and clip limits
  // ----------------------------------------------------------------
  localparam int DMAC_ACC_W = 40;
  localparam logic [39:0] DMAC_MAX31 = 40'h00_7FFF_FFFF;
  localparam logic [39:0] DMAC_MIN31 = 40'hFF_8000_0000;
  localparam logic [39:0] DMAC_MAX39 = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] DMAC_MIN39 = 40'h80_0000_0000;
  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DMAC_OP_NONE = 4'h0,
    DMAC_OP_MUL = 4'h1,
    DMAC_OP_MAC = 4'h2,
    DMAC_OP_MSC = 4'h3,
    DMAC_OP_ADD = 4'h4,
    DMAC_OP_SUB = 4'h5,
    DMAC_OP_LOAD = 4'h6,
    DMAC_OP_CLR = 4'h7
  } dmac_op_t;
endpackage

//--- rtl/dmac_mult.sv
// Purpose: 17x17 multiplier with integer/fractional scaler
// Assumes: combinational, one result per cycle
// Notes: result is 33 bits, sign-extended to the accumulator width
`timescale 1ns/1ns
`default_nettype none
module dmac_mult (
  input wire logic [15:0] op_a,
  input wire logic [15:0] op_b,
  input wire logic sign_a,
  input wire logic sign_b,
  input wire logic frac_mode,
  output logic [32:0] prod33,
  output logic [39:0] prod40
);
  import dmac_pkg::*;
  logic [16:0] ext_a;
  logic [16:0] ext_b;
  logic [33:0] raw;

  // widen operands: sign or zero into bit 16
  assign ext_a = {sign_a & op_a[15], op_a};
  assign ext_b = {sign_b & op_b[15], op_b};
  // signed 17x17 product, operands widened to the product width first
  assign raw = $signed({{17{ext_a[16]}}, ext_a}) * $signed({{17{ext_b[16]}}, ext_b});
  // fractional shifts left one: 1.15 x 1.15 to 1.31
  assign prod33 = frac_mode ? {raw[31:0], 1'b0} : raw[32:0];
  assign prod40 = {{7{prod33[32]}}, prod33};
endmodule
`default_nettype wire

//--- rtl/dmac_clip.sv
// Purpose: adder result flags and saturation decision
// Assumes: combinational, fed by the 40-bit adder
// Notes: mode 1 clips at bit 39, mode 0 at bit 31
`timescale 1ns/1ns
`default_nettype none
module dmac_clip (
  input wire logic [39:0] sum,
  input wire logic carry_ovf,
  input wire logic clip_en,
  input wire logic clip_mode,
  output logic guard_ovf,
  output logic clipped,
  output logic [39:0] result
);
  import dmac_pkg::*;
  logic ovf31;

  // guard bits 39..32 not all equal
  assign guard_ovf = ~((&sum[39:32]) | ~(|sum[39:32]));
  // bits 39..31 not all equal: result beyond the 32-bit range
  assign ovf31 = ~((&sum[39:31]) | ~(|sum[39:31]));
  // pick clip value with sign of true result
  always_comb begin
    result = sum;
    clipped = 1'b0;
    if (clip_en) begin
      if (clip_mode && carry_ovf) begin
        clipped = 1'b1;
        result = sum[39] ? DMAC_MAX39 : DMAC_MIN39;
      end else if (!clip_mode && (ovf31 || carry_ovf)) begin
        clipped = 1'b1;
        result = (carry_ovf ? ~sum[39] : sum[39]) ? DMAC_MIN31 : DMAC_MAX31;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/dmac_top.sv
// Purpose: multiply-accumulate datapath with AHB-Lite register access
// Assumes: single AHB-Lite master, word transfers, 10 MHz hclk
// Notes: a write to the command register runs one operation
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module dmac_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic acc_first_guard_overflow,
  output logic acc_second_guard_overflow,
  output logic acc_first_clip_flag,
  output logic acc_second_clip_flag,
  output logic either_acc_guard_overflow,
  output logic either_acc_clip_flag,
  output logic arith_trap_req
);
  import dmac_pkg::*;

  // ----------------------------------------------------------------
  // bus address phase capture
  // ----------------------------------------------------------------
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] addr_ff;
  logic take;

  assign take = hsel & hready & htrans[1];

  // latch the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= take & hwrite;
      rd_pend_ff <= take & ~hwrite;
      if (take) begin
        addr_ff <= haddr[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [15:0] op_a_ff;
  logic [15:0] op_b_ff;
  logic [7:0] core_ctl_ff;
  logic [1:0] trap_ctl_ff;
  logic [15:0] cmd_ff;
  logic go_ff;
  logic wr_a;
  logic wr_b;
  logic wr_cmd;
  logic wr_ctl;
  logic wr_trap;

  assign wr_a = wr_pend_ff && addr_ff == DMAC_OP_A_OFS;
  assign wr_b = wr_pend_ff && addr_ff == DMAC_OP_B_OFS;
  assign wr_cmd = wr_pend_ff && addr_ff == DMAC_CMD_OFS;
  assign wr_ctl = wr_pend_ff && addr_ff == DMAC_CORE_CTL_OFS;
  assign wr_trap = wr_pend_ff && addr_ff == DMAC_TRAP_CTL_OFS;

  // operand registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_a_ff <= 16'h0000;
      op_b_ff <= 16'h0000;
    end else begin
      if (wr_a) begin
        op_a_ff <= hwdata[15:0];
      end
      if (wr_b) begin
        op_b_ff <= hwdata[15:0];
      end
    end
  end

  // control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_ctl_ff <= DMAC_CORE_CTL_RST;
      trap_ctl_ff <= DMAC_TRAP_CTL_RST;
    end else begin
      if (wr_ctl) begin
        core_ctl_ff <= hwdata[7:0];
      end
      if (wr_trap) begin
        trap_ctl_ff <= hwdata[1:0];
      end
    end
  end

  // command capture, one-cycle go pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_ff <= 16'h0000;
      go_ff <= 1'b0;
    end else begin
      go_ff <= wr_cmd;
      if (wr_cmd) begin
        cmd_ff <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  dmac_op_t op;
  logic sel_second;
  logic frac_mode;
  logic [4:0] shamt;

  assign op = dmac_op_t'(cmd_ff[DMAC_CMD_OP_LSB +: 4]);
  assign sel_second = cmd_ff[DMAC_CMD_ACC_BIT];
  assign frac_mode = core_ctl_ff[DMAC_CTL_FRAC_BIT];
  assign shamt = cmd_ff[DMAC_CMD_SHIFT_LSB +: 5];

  // ----------------------------------------------------------------
  // multiplier
  // ----------------------------------------------------------------
  logic [32:0] prod33;
  logic [39:0] prod40;
  logic byte_mul;
  logic [15:0] mul_a;
  logic [15:0] mul_b;

  // low byte widened per its sign select
  function automatic logic [15:0] byte_ext(input logic [15:0] v, input logic sgn);
    byte_ext = {{8{sgn & v[7]}}, v[7:0]};
  endfunction

  // byte multiply feeds only the low operand bytes
  assign byte_mul = cmd_ff[DMAC_CMD_BYTE_BIT] && (op == DMAC_OP_MUL);
  assign mul_a = byte_mul ? byte_ext(op_a_ff, cmd_ff[DMAC_CMD_SIGN_A_BIT]) : op_a_ff;
  assign mul_b = byte_mul ? byte_ext(op_b_ff, cmd_ff[DMAC_CMD_SIGN_B_BIT]) : op_b_ff;

  dmac_mult u_mult (
    .op_a(mul_a),
    .op_b(mul_b),
    .sign_a(cmd_ff[DMAC_CMD_SIGN_A_BIT]),
    .sign_b(cmd_ff[DMAC_CMD_SIGN_B_BIT]),
    .frac_mode(frac_mode & (op == DMAC_OP_MAC || op == DMAC_OP_MSC)),
    .prod33(prod33),
    .prod40(prod40)
  );

  // ----------------------------------------------------------------
  // accumulators and adder
  // ----------------------------------------------------------------
  logic [39:0] acc_first_ff;
  logic [39:0] acc_second_ff;
  logic [39:0] src_acc;
  logic [39:0] load_data;
  logic [39:0] operand;
  logic [39:0] side_a;
  logic subtract;
  logic zero_a;
  logic uses_adder;
  logic [40:0] sum41;
  logic carry_ovf;

  assign src_acc = sel_second ? acc_second_ff : acc_first_ff;
  // operand A as 40-bit signed, scaled by the barrel shifter
  assign load_data = $signed({{24{op_a_ff[15]}}, op_a_ff}) <<< shamt;

  // choose adder inputs per operation
  always_comb begin
    operand = 40'h00_0000_0000;
    subtract = 1'b0;
    zero_a = 1'b0;
    uses_adder = 1'b1;
    unique case (op)
      DMAC_OP_MAC: operand = prod40;
      DMAC_OP_MSC: begin
        operand = prod40;
        subtract = 1'b1;
      end
      DMAC_OP_ADD: operand = load_data;
      DMAC_OP_SUB: begin
        operand = load_data;
        subtract = 1'b1;
      end
      DMAC_OP_LOAD: begin
        operand = load_data;
        zero_a = 1'b1;
      end
      DMAC_OP_CLR: zero_a = 1'b1;
      DMAC_OP_NONE, DMAC_OP_MUL: uses_adder = 1'b0;
      default: uses_adder = 1'b0;
    endcase
  end

  assign side_a = zero_a ? 40'h00_0000_0000 : src_acc;
  // borrow-in low means carry-in high on complement path
  assign sum41 = {1'b0, side_a} + {1'b0, subtract ? ~operand : operand}
    + {40'h00_0000_0000, subtract};
  // signed overflow out of bit 39
  assign carry_ovf = (side_a[39] == (subtract ? ~operand[39] : operand[39]))
    && (sum41[39] != side_a[39]);

  logic guard_ovf;
  logic clipped;
  logic [39:0] clip_result;

  dmac_clip u_clip (
    .sum(sum41[39:0]),
    .carry_ovf(carry_ovf),
    .clip_en(sel_second ? core_ctl_ff[DMAC_CTL_SECOND_CLIP_EN_BIT]
      : core_ctl_ff[DMAC_CTL_FIRST_CLIP_EN_BIT]),
    .clip_mode(core_ctl_ff[DMAC_CTL_CLIP_MODE_BIT]),
    .guard_ovf(guard_ovf),
    .clipped(clipped),
    .result(clip_result)
  );

  // accumulator write-back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_first_ff <= DMAC_ACC_RST;
      acc_second_ff <= DMAC_ACC_RST;
    end else if (go_ff && uses_adder) begin
      if (sel_second) begin
        acc_second_ff <= clip_result;
      end else begin
        acc_first_ff <= clip_result;
      end
    end
  end

  // ----------------------------------------------------------------
  // general product result
  // ----------------------------------------------------------------
  logic [31:0] product_ff;

  // byte mode keeps 16 bits, word mode 32
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      product_ff <= 32'h0000_0000;
    end else if (go_ff && op == DMAC_OP_MUL) begin
      if (cmd_ff[DMAC_CMD_BYTE_BIT]) begin
        product_ff <= {16'h0000, prod33[15:0]};
      end else begin
        product_ff <= prod33[31:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic first_cata_ff;
  logic second_cata_ff;

  // latched per operation; only latest op counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_first_guard_overflow <= 1'b0;
      acc_second_guard_overflow <= 1'b0;
      acc_first_clip_flag <= 1'b0;
      acc_second_clip_flag <= 1'b0;
      first_cata_ff <= 1'b0;
      second_cata_ff <= 1'b0;
    end else if (go_ff && uses_adder) begin
      if (sel_second) begin
        acc_second_guard_overflow <= guard_ovf | carry_ovf;
        acc_second_clip_flag <= clipped;
        second_cata_ff <= carry_ovf;
      end else begin
        acc_first_guard_overflow <= guard_ovf | carry_ovf;
        acc_first_clip_flag <= clipped;
        first_cata_ff <= carry_ovf;
      end
    end
  end

  // combined flags and trap request, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      either_acc_guard_overflow <= 1'b0;
      either_acc_clip_flag <= 1'b0;
      arith_trap_req <= 1'b0;
    end else begin
      either_acc_guard_overflow <= acc_first_guard_overflow
        | acc_second_guard_overflow;
      either_acc_clip_flag <= acc_first_clip_flag | acc_second_clip_flag;
      arith_trap_req <= (acc_first_guard_overflow & trap_ctl_ff[DMAC_TRAP_FIRST_EN_BIT])
        | (acc_second_guard_overflow & trap_ctl_ff[DMAC_TRAP_SECOND_EN_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  assign status_word = {23'h00_0000, arith_trap_req, second_cata_ff, first_cata_ff,
    either_acc_clip_flag, either_acc_guard_overflow, acc_second_clip_flag,
    acc_first_clip_flag, acc_second_guard_overflow, acc_first_guard_overflow};

  always_comb begin
    unique case (haddr[7:0])
      DMAC_OP_A_OFS: rd_mux = {16'h0000, op_a_ff};
      DMAC_OP_B_OFS: rd_mux = {16'h0000, op_b_ff};
      DMAC_CMD_OFS: rd_mux = {16'h0000, cmd_ff};
      DMAC_CORE_CTL_OFS: rd_mux = {24'h00_0000, core_ctl_ff};
      DMAC_TRAP_CTL_OFS: rd_mux = {30'h0000_0000, trap_ctl_ff};
      DMAC_STATUS_OFS: rd_mux = status_word;
      DMAC_ACC_FIRST_LO_OFS: rd_mux = acc_first_ff[31:0];
      DMAC_ACC_FIRST_HI_OFS: rd_mux = {{24{acc_first_ff[39]}}, acc_first_ff[39:32]};
      DMAC_ACC_SECOND_LO_OFS: rd_mux = acc_second_ff[31:0];
      DMAC_ACC_SECOND_HI_OFS: rd_mux = {{24{acc_second_ff[39]}}, acc_second_ff[39:32]};
      DMAC_PRODUCT_OFS: rd_mux = product_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered at end of address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- testbench/dmac_top_properties.sv
// Purpose: port-level checks of the multiply-accumulate datapath
// Assumes: single hclk domain, hresetn async active low
// Notes: flags show a change three sampled edges after a command address phase
`timescale 1ns/1ns
`default_nettype none
module dmac_top_properties
  import dmac_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic acc_first_guard_overflow,
  input wire logic acc_second_guard_overflow,
  input wire logic acc_first_clip_flag,
  input wire logic acc_second_clip_flag,
  input wire logic either_acc_guard_overflow,
  input wire logic either_acc_clip_flag,
  input wire logic arith_trap_req
);
  logic cmd_seen;
  // command write taken in this address phase
  assign cmd_seen = hsel & hready & htrans[1] & hwrite & (haddr[7:0] == DMAC_CMD_OFS);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready; hreadyout == 1'h1; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; hresp == 1'h0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_either_guard;
    either_acc_guard_overflow == $past(acc_first_guard_overflow | acc_second_guard_overflow);
  endproperty
  a_either_guard: assert property (p_either_guard) else $error("combined guard");
  property p_either_clip;
    either_acc_clip_flag == $past(acc_first_clip_flag | acc_second_clip_flag);
  endproperty
  a_either_clip: assert property (p_either_clip) else $error("combined clip");
  property p_first_clip; !$stable(acc_first_clip_flag) |-> $past(cmd_seen, 3); endproperty
  a_first_clip: assert property (p_first_clip) else $error("first clip moved");
  property p_second_clip; !$stable(acc_second_clip_flag) |-> $past(cmd_seen, 3); endproperty
  a_second_clip: assert property (p_second_clip) else $error("second clip moved");
  property p_trap;
    arith_trap_req |-> $past(acc_first_guard_overflow | acc_second_guard_overflow);
  endproperty
  a_trap: assert property (p_trap) else $error("trap without flag");
  property p_first_cause; !$stable(acc_first_guard_overflow) |-> $past(cmd_seen, 3); endproperty
  a_first_cause: assert property (p_first_cause) else $error("first flag moved");
  property p_second_cause; !$stable(acc_second_guard_overflow) |-> $past(cmd_seen, 3); endproperty
  a_second_cause: assert property (p_second_cause) else $error("second flag moved");
endmodule
bind dmac_top dmac_top_properties i_dmac_top_properties (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .acc_first_guard_overflow(acc_first_guard_overflow),
  .acc_second_guard_overflow(acc_second_guard_overflow),
  .acc_first_clip_flag(acc_first_clip_flag),
  .acc_second_clip_flag(acc_second_clip_flag),
  .either_acc_guard_overflow(either_acc_guard_overflow),
  .either_acc_clip_flag(either_acc_clip_flag),
  .arith_trap_req(arith_trap_req)
);
`default_nettype wire

//--- testbench/dmac_bus_master.sv
// Purpose: AHB-Lite single-word master standing in for the core decoder
// Assumes: one slave whose hreadyout is hready
// Notes: each finished read bumps rd_count with rd_value
`timescale 1ns/1ns
`default_nettype none
module dmac_bus_master (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic [31:0] rd_value,
  output logic [15:0] rd_count
);
  // idle bus at time zero
  initial begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_value = 32'h0;
    rd_count = 16'h0;
  end
  task automatic addr_phase(input logic [31:0] a, input logic w);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    addr_phase(a, 1'h1);
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
  endtask
  task automatic rd(input logic [31:0] a);
    addr_phase(a, 1'h0);
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hready !== 1'h1);
    rd_value <= hrdata;
    rd_count <= rd_count + 16'h1;
  endtask
endmodule
`default_nettype wire

//--- testbench/dmac_top_tb.sv
// Purpose: self-checking bench of the multiply-accumulate datapath
// Assumes: 10 MHz hclk, zero-wait slave
// Notes: expected reads queue up, a monitor compares them
`timescale 1ns/1ns
`default_nettype none
module dmac_top_tb;
  import dmac_pkg::*;
  typedef struct { string nm; logic [31:0] ev; logic [31:0] mk; } dmac_note_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic g1, g2, c1, c2, eg, ec, trap;
  logic [31:0] haddr, hwdata, hrdata, rd_value, a32, b32, ev;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] rd_count;
  dmac_note_t notes_q[$];
  dmac_note_t cur;
  int miscompares, checks_done, seed;
  dmac_top i_dmac_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .acc_first_guard_overflow(g1),
    .acc_second_guard_overflow(g2), .acc_first_clip_flag(c1), .acc_second_clip_flag(c2),
    .either_acc_guard_overflow(eg), .either_acc_clip_flag(ec), .arith_trap_req(trap));
  dmac_bus_master i_dmac_bus_master (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .rd_value(rd_value), .rd_count(rd_count));
  initial hclk = 1'h0;
  always #50 hclk = ~hclk;
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    repeat (2) @(posedge hclk);
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // note the expectation, then read
  task automatic look(input string nm, input logic [7:0] ofs, input logic [31:0] e,
                      input logic [31:0] mk);
    notes_q.push_back('{nm, e, mk});
    i_dmac_bus_master.rd({24'h0, ofs});
  endtask
  task automatic set(input logic [7:0] ofs, input logic [31:0] d);
    i_dmac_bus_master.wr({24'h0, ofs}, d);
  endtask
  task automatic st(input logic [31:0] e);
    look("status", DMAC_STATUS_OFS, e, 32'h0000_01FF);
  endtask
  // run one command, then read the selected accumulator
  task automatic op(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
                    input logic [31:0] lo, input logic [31:0] hi);
    set(DMAC_OP_A_OFS, {16'h0, a});
    set(DMAC_OP_B_OFS, {16'h0, b});
    set(DMAC_CMD_OFS, {16'h0, c});
    repeat (2) @(posedge hclk);
    look("acc_lo", c[4] ? DMAC_ACC_SECOND_LO_OFS : DMAC_ACC_FIRST_LO_OFS, lo, 32'hFFFF_FFFF);
    look("acc_hi", c[4] ? DMAC_ACC_SECOND_HI_OFS : DMAC_ACC_FIRST_HI_OFS, hi, 32'hFFFF_FFFF);
  endtask
  // 17-bit widened product, low 32 bits
  function automatic logic [31:0] mulx(input logic [15:0] a, input logic [15:0] b,
                                       input logic sa, input logic sb);
    logic signed [33:0] x;
    logic signed [33:0] y;
    x = {{18{sa & a[15]}}, a};
    y = {{18{sb & b[15]}}, b};
    mulx = 32'(x * y);
  endfunction
  // compare each finished read with the oldest note
  always @(rd_count) begin
    if (notes_q.size() > 0) begin
      cur = notes_q.pop_front();
      check(cur.nm, rd_value & cur.mk, cur.ev & cur.mk);
    end
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    hresetn = 1'h0;
    seed = 33958;
    miscompares = 0;
    checks_done = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    for (int k = 0; k < 13; k++) look("reset", 8'(k * 4), 32'h0, 32'hFFFF_FFFF);
    for (int k = 0; k < 8; k++) begin
      a32 = $random(seed);
      b32 = $random(seed);
      set(DMAC_OP_A_OFS, {16'h0, a32[15:0]});
      set(DMAC_OP_B_OFS, {16'h0, b32[15:0]});
      set(DMAC_CMD_OFS, {24'h0, k[2], k[1], k[0], 5'h01});
      repeat (2) @(posedge hclk);
      if (k[2]) ev = mulx({{8{k[0] & a32[7]}}, a32[7:0]}, {{8{k[1] & b32[7]}}, b32[7:0]},
                          k[0], k[1]);
      else ev = mulx(a32[15:0], b32[15:0], k[0], k[1]);
      look("product", DMAC_PRODUCT_OFS, ev, k[2] ? 32'h0000_FFFF : 32'hFFFF_FFFF);
    end
    op(16'h0, 16'h0, 16'h0007, 32'h0, 32'h0);
    op(16'h4000, 16'h4000, 16'h0062, 32'h1000_0000, 32'h0);
    set(DMAC_CORE_CTL_OFS, 32'h1);
    op(16'h0, 16'h0, 16'h0007, 32'h0, 32'h0);
    op(16'h4000, 16'h4000, 16'h0062, 32'h2000_0000, 32'h0);
    op(16'h0, 16'h0, 16'h0007, 32'h0, 32'h0);
    op(16'h8000, 16'h8000, 16'h0062, 32'h8000_0000, 32'h0);
    st(32'h0);
    op(16'h8000, 16'h8000, 16'h0063, 32'h0, 32'h0);
    set(DMAC_CORE_CTL_OFS, 32'h0);
    op(16'hFFFF, 16'h0001, 16'h0062, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    op(16'hFFFF, 16'h0001, 16'h0002, 32'h0000_FFFE, 32'h0);
    op(16'h1234, 16'h0, 16'h0426, 32'h0001_2340, 32'h0);
    op(16'h0001, 16'h0, 16'h0024, 32'h0001_2341, 32'h0);
    op(16'h0002, 16'h0, 16'h0025, 32'h0001_233F, 32'h0);
    look("acc2_lo", DMAC_ACC_SECOND_LO_OFS, 32'h0, 32'hFFFF_FFFF);
    op(16'h7FFF, 16'h0, 16'h1426, 32'hFFF0_0000, 32'h7);
    st(32'h11);
    set(DMAC_CORE_CTL_OFS, 32'h80);
    op(16'h7FFF, 16'h0, 16'h1426, 32'h7FFF_FFFF, 32'h0);
    st(32'h35);
    op(16'h8000, 16'h0, 16'h1426, 32'h8000_0000, 32'hFFFF_FFFF);
    set(DMAC_TRAP_CTL_OFS, 32'h1);
    st(32'h135);
    set(DMAC_TRAP_CTL_OFS, 32'h0);
    set(DMAC_CORE_CTL_OFS, 32'h90);
    op(16'h7FFF, 16'h0, 16'h1826, 32'hFF00_0000, 32'h7F);
    st(32'h11);
    op(16'h7FFF, 16'h0, 16'h1824, 32'hFFFF_FFFF, 32'h7F);
    st(32'h75);
    op(16'h0001, 16'h0, 16'h0026, 32'h1, 32'h0);
    st(32'h0);
    set(DMAC_CORE_CTL_OFS, 32'h40);
    set(DMAC_TRAP_CTL_OFS, 32'h2);
    op(16'h7FFF, 16'h0, 16'h1436, 32'h7FFF_FFFF, 32'h0);
    st(32'h13A);
    look("acc1_lo", DMAC_ACC_FIRST_LO_OFS, 32'h1, 32'hFFFF_FFFF);
    set(DMAC_CORE_CTL_OFS, 32'h80);
    op(16'h4000, 16'h0, 16'h1126, 32'h7FFF_FFFF, 32'h0);
    st(32'h13E);
    summarize();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge hclk);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
